/* File: src/fsc_pkg.sv */
// Package: register map, field positions, reset values and encodings of the loop-2 config block
package fsc_pkg;
  // ****************************************
  // Register addresses (register index, 16-bit data)
  // ****************************************
  localparam int ADDR_W = 10;
  localparam int DATA_W = 16;
  localparam logic [ADDR_W-1:0] ADDR_CTRL_1 = 10'h191;
  localparam logic [ADDR_W-1:0] ADDR_CTRL_2 = 10'h192;
  localparam logic [ADDR_W-1:0] ADDR_CTRL_3 = 10'h193;
  localparam logic [ADDR_W-1:0] ADDR_CTRL_4 = 10'h194;
  localparam logic [ADDR_W-1:0] ADDR_CTRL_5 = 10'h195;
  localparam logic [ADDR_W-1:0] ADDR_CTRL_6 = 10'h196;
  localparam logic [ADDR_W-1:0] ADDR_CTRL_7 = 10'h199;
  localparam logic [ADDR_W-1:0] ADDR_EFS_2 = 10'h19A;
  localparam logic [ADDR_W-1:0] ADDR_SYNC_1 = 10'h1A1;
  localparam logic [ADDR_W-1:0] ADDR_SYNC_2 = 10'h1A2;
  localparam logic [ADDR_W-1:0] ADDR_SYNC_3 = 10'h1A3;
  localparam logic [ADDR_W-1:0] ADDR_SYNC_4 = 10'h1A4;
  localparam logic [ADDR_W-1:0] ADDR_SYNC_5 = 10'h1A5;
  localparam logic [ADDR_W-1:0] ADDR_SYNC_6 = 10'h1A6;
  localparam logic [ADDR_W-1:0] ADDR_SYNC_7 = 10'h1A7;
  localparam logic [ADDR_W-1:0] ADDR_SPREAD = 10'h1A9;
  localparam logic [ADDR_W-1:0] ADDR_STATUS = 10'h1AE;
  localparam logic [ADDR_W-1:0] ADDR_GPIO_CFG = 10'h1AF;
  // ****************************************
  // Field positions
  // ****************************************
  localparam int POS_ENA = 0;
  localparam int POS_FREERUN = 1;
  localparam int POS_UPD = 15;
  localparam int POS_FRATIO = 8;
  localparam int POS_REFDIV = 6;
  localparam int POS_GAIN = 2;
  localparam int POS_PHASE = 11;
  localparam int POS_BW = 0;
  localparam int POS_SS_AMPL = 4;
  localparam int POS_SS_FREQ = 2;
  localparam int POS_SS_SEL = 0;
  localparam int POS_ST_LOCK = 0;
  localparam int POS_ST_CHG = 1;
  // ****************************************
  // Reset values
  // ****************************************
  localparam logic RST_FREERUN = 1'b1;
  localparam logic [9:0] RST_INT_MULT = 10'h008;
  localparam logic [15:0] RST_FRAC_NUM = 16'h0018;
  localparam logic [15:0] RST_FRAC_DEN = 16'h007D;
  localparam logic RST_PHASE = 1'b1;
  localparam logic RST_SYNC_BW = 1'b1;
  // ****************************************
  // Encodings
  // ****************************************
  typedef enum logic [1:0] {
    FSC_SS_OFF = 2'h0,
    FSC_SS_ZERO_MEAN = 2'h1,
    FSC_SS_TRIANGLE = 2'h2,
    FSC_SS_DITHER = 2'h3
  } fsc_spread_t;
  typedef enum logic [1:0] {
    FSC_GPIO_OFF = 2'h0,
    FSC_GPIO_LOCK = 2'h1,
    FSC_GPIO_CLOCK = 2'h2
  } fsc_gpio_t;
endpackage

/* File: src/fsc_top.sv */
// Loop-2 ratio, spread-spectrum and synchronizer configuration with lock status and pin routing
// Behaviour
// - Bandwidth bit: 0 wide, 1 narrow, resets 1
// - Amplitude bits 5:4 select modulation depth
// - Rate bits 3:2 used in triangle only
// - Select bits 1:0 off/zero-mean/triangle/dither
// - Lock indication follows loop frequency lock
// - Lock level and changes feed interrupt logic
// - Lock may drive general-purpose pin unmodified
// - Loop-derived clock may drive general-purpose pin
// - Output frequency follows divider, ratio, output divide
// - Ratio is integer plus numerator over denominator
// - Synchronizer divide code differs from main code
// - While enabled, update strobe applies integer and numerator
`timescale 1ns/100ps
module fsc_top (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic [fsc_pkg::ADDR_W-1:0] reg_addr,
  input wire logic [fsc_pkg::DATA_W-1:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [fsc_pkg::DATA_W-1:0] reg_rdata,
  input wire logic loop_lock_in,
  input wire logic loop_clk_in,
  output logic loop_enable,
  output logic loop_freerun,
  output logic [9:0] int_mult,
  output logic [15:0] frac_num,
  output logic [15:0] frac_den,
  output logic [3:0] out_div_code,
  output logic [1:0] ref_div_code,
  output logic [3:0] ref_src,
  output logic [3:0] loop_gain,
  output logic phase_int_enable,
  output logic sync_enable,
  output logic [9:0] sync_int_mult,
  output logic [15:0] sync_num,
  output logic [15:0] sync_den,
  output logic [2:0] sync_div_code,
  output logic [1:0] sync_ref_div_code,
  output logic [3:0] sync_ref_src,
  output logic [3:0] sync_gain,
  output logic sync_bw_narrow,
  output logic [1:0] spread_amplitude,
  output logic [1:0] spread_triangle_rate,
  output logic [1:0] spread_mode,
  output logic lock_status,
  output logic lock_event,
  output logic gpio_out
);
  // ****************************************
  // State
  // ****************************************
  typedef struct packed {
    logic ena;
    logic freerun;
    logic [9:0] n_prog;
    logic [15:0] num_prog;
    logic [9:0] n_act;
    logic [15:0] num_act;
    logic [15:0] den;
    logic [3:0] fratio;
    logic [1:0] refdiv;
    logic [3:0] refsrc;
    logic [3:0] gain;
    logic phase;
    logic s_ena;
    logic [9:0] s_n;
    logic [15:0] s_num;
    logic [15:0] s_den;
    logic [2:0] s_fratio;
    logic [1:0] s_refdiv;
    logic [3:0] s_refsrc;
    logic [3:0] s_gain;
    logic s_bw;
    logic [1:0] ss_ampl;
    logic [1:0] ss_freq;
    logic [1:0] ss_sel;
    logic [1:0] ss_rate_eff;
    logic [1:0] gpio_fn;
    logic [1:0] lock_meta;
    logic lock;
    logic lock_chg;
    logic lock_pulse;
    logic [1:0] clk_meta;
    logic gpio;
    logic [fsc_pkg::DATA_W-1:0] rdata;
  } fsc_state_t;

  fsc_state_t st_r;
  fsc_state_t st_nxt;
  logic wr_hit;

  // ****************************************
  // Next-state logic
  // ****************************************
  // One combinational pass builds the whole next state
  always_comb begin
    st_nxt = st_r;
    st_nxt.lock_pulse = 1'b0;
    // Register writes
    if (reg_wr) begin
      case (reg_addr)
        fsc_pkg::ADDR_CTRL_1: begin
          st_nxt.ena = reg_wdata[fsc_pkg::POS_ENA];
          st_nxt.freerun = reg_wdata[fsc_pkg::POS_FREERUN];
        end
        fsc_pkg::ADDR_CTRL_2: begin
          st_nxt.n_prog = reg_wdata[9:0];
        end
        fsc_pkg::ADDR_CTRL_3: begin
          st_nxt.num_prog = reg_wdata;
        end
        fsc_pkg::ADDR_CTRL_4: begin
          st_nxt.den = reg_wdata;
        end
        fsc_pkg::ADDR_CTRL_5: begin
          st_nxt.fratio = reg_wdata[fsc_pkg::POS_FRATIO +: 4];
        end
        fsc_pkg::ADDR_CTRL_6: begin
          st_nxt.refdiv = reg_wdata[fsc_pkg::POS_REFDIV +: 2];
          st_nxt.refsrc = reg_wdata[3:0];
        end
        fsc_pkg::ADDR_CTRL_7: begin
          st_nxt.gain = reg_wdata[fsc_pkg::POS_GAIN +: 4];
        end
        fsc_pkg::ADDR_EFS_2: begin
          st_nxt.phase = reg_wdata[fsc_pkg::POS_PHASE];
        end
        fsc_pkg::ADDR_SYNC_1: begin
          st_nxt.s_ena = reg_wdata[fsc_pkg::POS_ENA];
        end
        fsc_pkg::ADDR_SYNC_2: begin
          st_nxt.s_n = reg_wdata[9:0];
        end
        fsc_pkg::ADDR_SYNC_3: begin
          st_nxt.s_num = reg_wdata;
        end
        fsc_pkg::ADDR_SYNC_4: begin
          st_nxt.s_den = reg_wdata;
        end
        fsc_pkg::ADDR_SYNC_5: begin
          st_nxt.s_fratio = reg_wdata[fsc_pkg::POS_FRATIO +: 3];
        end
        fsc_pkg::ADDR_SYNC_6: begin
          st_nxt.s_refdiv = reg_wdata[fsc_pkg::POS_REFDIV +: 2];
          st_nxt.s_refsrc = reg_wdata[3:0];
        end
        fsc_pkg::ADDR_SYNC_7: begin
          st_nxt.s_gain = reg_wdata[fsc_pkg::POS_GAIN +: 4];
          st_nxt.s_bw = reg_wdata[fsc_pkg::POS_BW];
        end
        fsc_pkg::ADDR_SPREAD: begin
          st_nxt.ss_ampl = reg_wdata[fsc_pkg::POS_SS_AMPL +: 2];
          st_nxt.ss_freq = reg_wdata[fsc_pkg::POS_SS_FREQ +: 2];
          st_nxt.ss_sel = reg_wdata[fsc_pkg::POS_SS_SEL +: 2];
        end
        fsc_pkg::ADDR_GPIO_CFG: begin
          st_nxt.gpio_fn = reg_wdata[1:0];
        end
        default: begin
        end
      endcase
    end
    // shadowed integer and numerator
    // Running loop sees a consistent pair only on the strobe, never a half-written ratio
    if (!st_r.ena) begin
      st_nxt.n_act = st_nxt.n_prog;
      st_nxt.num_act = st_nxt.num_prog;
    end else if (wr_hit && reg_wdata[fsc_pkg::POS_UPD]) begin
      st_nxt.n_act = st_nxt.n_prog;
      st_nxt.num_act = st_nxt.num_prog;
    end
    if (st_nxt.ss_sel == fsc_pkg::FSC_SS_TRIANGLE) begin
      st_nxt.ss_rate_eff = st_nxt.ss_freq;
    end else begin
      st_nxt.ss_rate_eff = 2'h0;
    end
    st_nxt.lock_meta = {st_r.lock_meta[0], loop_lock_in};
    st_nxt.lock = st_r.lock_meta[1];
    // change pulse and sticky change flag
    if (reg_wr && reg_addr == fsc_pkg::ADDR_STATUS && reg_wdata[fsc_pkg::POS_ST_CHG]) begin
      st_nxt.lock_chg = 1'b0;
    end
    if (st_r.lock_meta[1] != st_r.lock) begin
      st_nxt.lock_pulse = 1'b1;
      st_nxt.lock_chg = 1'b1;
    end
    // Loop clock is sampled, so only clocks below half of clk pass faithfully
    st_nxt.clk_meta = {st_r.clk_meta[0], loop_clk_in};
    case (st_r.gpio_fn)
      fsc_pkg::FSC_GPIO_LOCK: begin
        st_nxt.gpio = st_r.lock;
      end
      fsc_pkg::FSC_GPIO_CLOCK: begin
        st_nxt.gpio = st_r.clk_meta[1];
      end
      default: begin
        st_nxt.gpio = 1'b0;
      end
    endcase
    // Read data, one cycle after the strobe; unmapped reads zero
    if (reg_rd) begin
      case (reg_addr)
        fsc_pkg::ADDR_CTRL_1: st_nxt.rdata = {14'h0000, st_r.freerun, st_r.ena};
        fsc_pkg::ADDR_CTRL_2: st_nxt.rdata = {6'h00, st_r.n_prog};
        fsc_pkg::ADDR_CTRL_3: st_nxt.rdata = st_r.num_prog;
        fsc_pkg::ADDR_CTRL_4: st_nxt.rdata = st_r.den;
        fsc_pkg::ADDR_CTRL_5: st_nxt.rdata = {4'h0, st_r.fratio, 8'h00};
        fsc_pkg::ADDR_CTRL_6: st_nxt.rdata = {8'h00, st_r.refdiv, 2'h0, st_r.refsrc};
        fsc_pkg::ADDR_CTRL_7: st_nxt.rdata = {10'h000, st_r.gain, 2'h0};
        fsc_pkg::ADDR_EFS_2: st_nxt.rdata = {4'h0, st_r.phase, 11'h000};
        fsc_pkg::ADDR_SYNC_1: st_nxt.rdata = {15'h0000, st_r.s_ena};
        fsc_pkg::ADDR_SYNC_2: st_nxt.rdata = {6'h00, st_r.s_n};
        fsc_pkg::ADDR_SYNC_3: st_nxt.rdata = st_r.s_num;
        fsc_pkg::ADDR_SYNC_4: st_nxt.rdata = st_r.s_den;
        fsc_pkg::ADDR_SYNC_5: st_nxt.rdata = {5'h00, st_r.s_fratio, 8'h00};
        fsc_pkg::ADDR_SYNC_6: st_nxt.rdata = {8'h00, st_r.s_refdiv, 2'h0, st_r.s_refsrc};
        fsc_pkg::ADDR_SYNC_7: st_nxt.rdata = {10'h000, st_r.s_gain, 1'b0, st_r.s_bw};
        fsc_pkg::ADDR_SPREAD: st_nxt.rdata = {10'h000, st_r.ss_ampl, st_r.ss_freq, st_r.ss_sel};
        fsc_pkg::ADDR_STATUS: st_nxt.rdata = {14'h0000, st_r.lock_chg, st_r.lock};
        fsc_pkg::ADDR_GPIO_CFG: st_nxt.rdata = {14'h0000, st_r.gpio_fn};
        default: st_nxt.rdata = 16'h0000;
      endcase
    end
  end

  // Write hitting the control register that carries the update strobe
  assign wr_hit = reg_wr && (reg_addr == fsc_pkg::ADDR_CTRL_2);

  // ****************************************
  // State register
  // ****************************************
  // Synchronous reset loads documented defaults
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      st_r <= '0;
      st_r.freerun <= fsc_pkg::RST_FREERUN;
      st_r.n_prog <= fsc_pkg::RST_INT_MULT;
      st_r.n_act <= fsc_pkg::RST_INT_MULT;
      st_r.num_prog <= fsc_pkg::RST_FRAC_NUM;
      st_r.num_act <= fsc_pkg::RST_FRAC_NUM;
      st_r.den <= fsc_pkg::RST_FRAC_DEN;
      st_r.phase <= fsc_pkg::RST_PHASE;
      st_r.s_bw <= fsc_pkg::RST_SYNC_BW;
    end else begin
      st_r <= st_nxt;
    end
  end

  // ****************************************
  // Outputs, all straight from state
  // ****************************************
  // ratio, dividers and gains to the oscillator
  assign loop_enable = st_r.ena;
  assign loop_freerun = st_r.freerun;
  assign int_mult = st_r.n_act;
  assign frac_num = st_r.num_act;
  assign frac_den = st_r.den;
  assign out_div_code = st_r.fratio;
  assign ref_div_code = st_r.refdiv;
  assign ref_src = st_r.refsrc;
  assign loop_gain = st_r.gain;
  assign phase_int_enable = st_r.phase;
  assign sync_enable = st_r.s_ena;
  assign sync_int_mult = st_r.s_n;
  assign sync_num = st_r.s_num;
  assign sync_den = st_r.s_den;
  assign sync_div_code = st_r.s_fratio;
  assign sync_ref_div_code = st_r.s_refdiv;
  assign sync_ref_src = st_r.s_refsrc;
  assign sync_gain = st_r.s_gain;
  assign sync_bw_narrow = st_r.s_bw;
  assign spread_amplitude = st_r.ss_ampl;
  assign spread_triangle_rate = st_r.ss_rate_eff;
  assign spread_mode = st_r.ss_sel;
  assign lock_status = st_r.lock;
  assign lock_event = st_r.lock_pulse;
  assign gpio_out = st_r.gpio;
  assign reg_rdata = st_r.rdata;
endmodule

/* File: verif/fsc_assertions.sv */
// Port checker for the loop-2 configuration block
`timescale 1ns/100ps
module fsc_checker (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic [fsc_pkg::ADDR_W-1:0] reg_addr,
  input wire logic [fsc_pkg::DATA_W-1:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic loop_lock_in,
  input wire logic loop_clk_in,
  input wire logic loop_enable,
  input wire logic [9:0] int_mult,
  input wire logic [15:0] frac_num,
  input wire logic sync_bw_narrow,
  input wire logic [1:0] spread_amplitude,
  input wire logic [1:0] spread_triangle_rate,
  input wire logic [1:0] spread_mode,
  input wire logic lock_status,
  input wire logic lock_event,
  input wire logic gpio_out
);
  logic [1:0] fn_r;
  logic [1:0] fn_nxt;
  logic [1:0] fn_d_r;
  logic upd;
  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);
  // ****************************************
  // Pin function mirror
  // ****************************************
  // Mirror of the pin function, delayed once to match the registered pin
  always_comb begin
    fn_nxt = fn_r;
    if (reg_wr && reg_addr == fsc_pkg::ADDR_GPIO_CFG) begin
      fn_nxt = reg_wdata[1:0];
    end
  end
  always_ff @(posedge clk) begin
    fn_r <= sys_rst ? 2'h0 : fn_nxt;
    fn_d_r <= sys_rst ? 2'h0 : fn_r;
  end
  assign upd = reg_wr && reg_addr == fsc_pkg::ADDR_CTRL_2 && reg_wdata[15];
  // ****************************************
  // Properties
  // ****************************************
  AST_SPREAD_WR: assert property (reg_wr && reg_addr == fsc_pkg::ADDR_SPREAD |=>
    spread_mode == $past(reg_wdata[1:0]) && spread_amplitude == $past(reg_wdata[5:4]))
    else $error("spread fields not loaded");
  AST_RATE_GATE: assert property (spread_mode != fsc_pkg::FSC_SS_TRIANGLE |-> spread_triangle_rate == 2'h0)
    else $error("rate code seen outside triangle mode");
  AST_BW_WR: assert property (reg_wr && reg_addr == fsc_pkg::ADDR_SYNC_7 |=>
    sync_bw_narrow == $past(reg_wdata[0])) else $error("bandwidth bit not loaded");
  AST_LOCK_FOLLOW: assert property ($stable(loop_lock_in)[*5] |-> lock_status == loop_lock_in)
    else $error("lock status lags its input");
  AST_LOCK_EVENT: assert property (!$past(sys_rst) |-> lock_event == $changed(lock_status))
    else $error("lock event does not match a status change");
  AST_GPIO_LOCK: assert property (fn_d_r == fsc_pkg::FSC_GPIO_LOCK |-> gpio_out == $past(lock_status))
    else $error("pin does not copy lock status");
  AST_GPIO_CLOCK: assert property ((fn_r == fsc_pkg::FSC_GPIO_CLOCK &&
    fn_d_r == fsc_pkg::FSC_GPIO_CLOCK && $stable(loop_clk_in))[*5] |-> gpio_out == loop_clk_in)
    else $error("pin does not follow loop clock");
  AST_SHADOW_HOLD: assert property (loop_enable && !upd && !(reg_wr && reg_addr == fsc_pkg::ADDR_CTRL_1) |=>
    $stable(int_mult) && $stable(frac_num)) else $error("active ratio moved without update");
  AST_SHADOW_UPD: assert property (loop_enable && upd |=> int_mult == $past(reg_wdata[9:0]))
    else $error("update strobe did not load multiplier");
  // Main scenarios reached
  cover property (lock_event);
  cover property (loop_enable && upd);
  cover property (spread_mode == fsc_pkg::FSC_SS_TRIANGLE && spread_triangle_rate != 2'h0);
endmodule
bind fsc_top fsc_checker u_chk (.clk, .sys_rst, .reg_addr, .reg_wdata, .reg_wr, .loop_lock_in, .loop_clk_in,
  .loop_enable, .int_mult, .frac_num, .sync_bw_narrow, .spread_amplitude, .spread_triangle_rate, .spread_mode,
  .lock_status, .lock_event, .gpio_out);

/* File: verif/fsc_top_tb_top.sv */
// Self-checking bench of the loop-2 configuration block
`timescale 1ns/100ps
module fsc_top_tb_top;
  logic clk = 1'b0;
  logic sys_rst = 1'b1;
  logic [9:0] reg_addr = 10'h000;
  logic [15:0] reg_wdata = 16'h0000;
  logic reg_wr = 1'b0, reg_rd = 1'b0, loop_lock_in = 1'b0, loop_clk_in = 1'b0;
  logic [15:0] reg_rdata, frac_num, frac_den, sync_num, sync_den;
  logic [9:0] int_mult, sync_int_mult;
  logic [3:0] out_div_code, ref_src, loop_gain, sync_ref_src, sync_gain;
  logic [2:0] sync_div_code;
  logic [1:0] ref_div_code, sync_ref_div_code, spread_amplitude, spread_triangle_rate, spread_mode;
  logic loop_enable, loop_freerun, phase_int_enable, sync_enable, sync_bw_narrow, lock_status, lock_event, gpio_out;
  int miscompares = 0;
  int cmp_count = 0;
  fsc_top dut (.clk, .sys_rst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .loop_lock_in, .loop_clk_in,
    .loop_enable, .loop_freerun, .int_mult, .frac_num, .frac_den, .out_div_code, .ref_div_code, .ref_src,
    .loop_gain, .phase_int_enable, .sync_enable, .sync_int_mult, .sync_num, .sync_den, .sync_div_code,
    .sync_ref_div_code, .sync_ref_src, .sync_gain, .sync_bw_narrow, .spread_amplitude, .spread_triangle_rate,
    .spread_mode, .lock_status, .lock_event, .gpio_out);
  // Free-running 250 MHz clock
  always #2 clk = ~clk;
  // ****************************************
  // Access and compare tasks
  // ****************************************
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    cmp_count++;
    if (got !== exp) begin
      miscompares++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // Strobe drops a full cycle before the next access may raise it
  task automatic wr(input logic [9:0] a, input logic [15:0] d);
    @(negedge clk);
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1'b1;
    @(negedge clk);
    reg_wr = 1'b0;
  endtask
  task automatic rd(input logic [9:0] a, input logic [15:0] exp);
    @(negedge clk);
    reg_addr = a;
    reg_rd = 1'b1;
    @(negedge clk);
    reg_rd = 1'b0;
    chk(reg_rdata, exp);
  endtask
  task automatic end_of_test;
    $display("comparisons %0d, mismatches %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  // ****************************************
  // Test sequence
  // ****************************************
  // Hang guard, far beyond the roughly 120 cycles the sequence needs
  initial begin
    repeat (3000) @(posedge clk);
    miscompares++;
    end_of_test;
  end
  initial begin
    logic [15:0] d;
    int n;
    repeat (8) @(negedge clk);
    sys_rst = 1'b0;
    chk({6'h00, int_mult}, 16'h0008);
    chk(frac_num, 16'h0018);
    chk(frac_den, 16'h007D);
    chk({15'h0000, sync_bw_narrow}, 16'h0001);
    chk({12'h000, loop_enable, loop_freerun, phase_int_enable, sync_enable}, 16'h0006);
    rd(fsc_pkg::ADDR_SYNC_7, 16'h0001);
    rd(fsc_pkg::ADDR_SPREAD, 16'h0000);
    rd(10'h1AA, 16'h0000);
    wr(fsc_pkg::ADDR_SYNC_7, 16'h0014);
    chk({11'h000, sync_gain, sync_bw_narrow}, 16'h000A);
    wr(fsc_pkg::ADDR_SYNC_7, 16'h0001);
    chk({11'h000, sync_gain, sync_bw_narrow}, 16'h0001);
    // Every mode once; rate only survives in triangle mode
    for (int m = 0; m < 4; m++) begin
      d = 16'(m * 16 + (3 - m) * 4 + m);
      wr(fsc_pkg::ADDR_SPREAD, d);
      chk({10'h000, spread_amplitude, spread_triangle_rate, spread_mode}, (m == 2) ? d : (d & 16'h0033));
      rd(fsc_pkg::ADDR_SPREAD, d);
    end
    // Enabled loop: new ratio waits for the update strobe
    wr(fsc_pkg::ADDR_CTRL_1, 16'h0001);
    chk({14'h0000, loop_freerun, loop_enable}, 16'h0001);
    wr(fsc_pkg::ADDR_CTRL_3, 16'h0002);
    wr(fsc_pkg::ADDR_CTRL_2, 16'h0155);
    chk({6'h00, int_mult}, 16'h0008);
    chk(frac_num, 16'h0018);
    rd(fsc_pkg::ADDR_CTRL_3, 16'h0002);
    wr(fsc_pkg::ADDR_CTRL_2, 16'h82AA);
    chk({6'h00, int_mult}, 16'h02AA);
    chk(frac_num, 16'h0002);
    rd(fsc_pkg::ADDR_CTRL_2, 16'h02AA);
    wr(fsc_pkg::ADDR_CTRL_1, 16'h0000);
    wr(fsc_pkg::ADDR_CTRL_2, 16'h0007);
    chk({6'h00, int_mult}, 16'h0007);
    wr(fsc_pkg::ADDR_CTRL_4, 16'h0659);
    chk(frac_den, 16'h0659);
    // Software ratio for a 32.768 kHz source: target is 3 x 1000 x source, so the fraction is 0 over 1
    wr(fsc_pkg::ADDR_CTRL_6, 16'h0001);
    wr(fsc_pkg::ADDR_CTRL_5, 16'h0200);
    wr(fsc_pkg::ADDR_CTRL_2, 16'h03E8);
    wr(fsc_pkg::ADDR_CTRL_3, 16'h0000);
    wr(fsc_pkg::ADDR_CTRL_4, 16'h0001);
    wr(fsc_pkg::ADDR_CTRL_7, 16'h0008);
    chk({6'h00, int_mult}, 16'h03E8);
    chk(frac_num, 16'h0000);
    chk(frac_den, 16'h0001);
    chk({out_div_code, ref_div_code, 2'h0, ref_src, loop_gain}, 16'h2012);
    // Synchronizer for the same source; its own divide code 1XX means 16
    wr(fsc_pkg::ADDR_SYNC_2, 16'h00BB);
    wr(fsc_pkg::ADDR_SYNC_3, 16'h0001);
    wr(fsc_pkg::ADDR_SYNC_4, 16'h0002);
    wr(fsc_pkg::ADDR_SYNC_5, 16'h0400);
    wr(fsc_pkg::ADDR_SYNC_6, 16'h0008);
    wr(fsc_pkg::ADDR_SYNC_7, 16'h0001);
    wr(fsc_pkg::ADDR_SYNC_1, 16'h0001);
    chk({6'h00, sync_int_mult}, 16'h00BB);
    chk(sync_num, 16'h0001);
    chk(sync_den, 16'h0002);
    chk({8'h00, sync_ref_div_code, 2'h0, sync_ref_src}, 16'h0008);
    chk({12'h000, sync_enable, sync_div_code}, 16'h000C);
    rd(fsc_pkg::ADDR_SYNC_5, 16'h0400);
    // Lock rise, event, sticky flag and pin copy
    wr(fsc_pkg::ADDR_GPIO_CFG, 16'h0001);
    loop_lock_in = 1'b1;
    n = 0;
    while (lock_status !== 1'b1 && n < 8) begin
      @(negedge clk);
      n++;
    end
    chk(16'(n), 16'h0003);
    chk({15'h0000, lock_event}, 16'h0001);
    @(negedge clk);
    chk({14'h0000, lock_event, gpio_out}, 16'h0001);
    rd(fsc_pkg::ADDR_STATUS, 16'h0003);
    wr(fsc_pkg::ADDR_STATUS, 16'h0002);
    rd(fsc_pkg::ADDR_STATUS, 16'h0001);
    loop_lock_in = 1'b0;
    repeat (5) @(negedge clk);
    chk({15'h0000, gpio_out}, 16'h0000);
    rd(fsc_pkg::ADDR_STATUS, 16'h0002);
    // Slow loop clock routed to the pin
    wr(fsc_pkg::ADDR_GPIO_CFG, 16'h0002);
    for (int k = 0; k < 4; k++) begin
      loop_clk_in = ~loop_clk_in;
      repeat (4) @(negedge clk);
      chk({15'h0000, gpio_out}, {15'h0000, loop_clk_in});
    end
    end_of_test;
  end
endmodule
